// file: core/irq_ctrl_pkg.sv
// Purpose: Constants shared by the two-level interrupt controller
// Assumes: Byte-wide special-function register port, one core clock
// Notes:   Source indices follow the fixed polling order, 0 first
//
// Overview of operation
// [R01] Gate bit 7 blocks all maskable requests
// [R02] Main enable bits 6..0 enable seven sources
// [R03] Priority bits 6..0 pick level; bit 7 reserved
// [R04] Secondary bits 2..0 enable interval, supply, serial
// [R05] Secondary bits 6..4 pick those sources' level
// [R06] Software always writes secondary bit 3 as 0
// [R07] High request preempts a low-level service routine
// [R08] Both levels pending: high level served first
// [R09] Same level never nests into an active routine
// [R10] Same level ties resolved by fixed polling order
// [R11] Accepted request: core pushes PC, loads vector
// [R12] Each source has its own fixed vector address
// [R13] Watchdog interrupt mode: timeout interrupts, no reset
// [R14] Watchdog always high level, ignores gate bit
// [R15] Watchdog interrupts only with nonzero timeout setting
// [R16] Reset: secondary A0h, main enable, priority zero
// [R17] Shared-vector flags are ORed into one request
// [R18] Return from interrupt clears the active level

package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EN_MAIN = 8'hA8;
  localparam logic [7:0] ADDR_EN_PRIO2 = 8'hA9;
  localparam logic [7:0] ADDR_PRIO_MAIN = 8'hB8;
  localparam logic [7:0] RST_EN_MAIN = 8'h00;
  localparam logic [7:0] RST_PRIO_MAIN = 8'h00;
  localparam logic [7:0] RST_EN_PRIO2 = 8'hA0;

  // ----------------------------------------------------------------
  // Field positions, main enable and main priority share them
  // ----------------------------------------------------------------
  localparam int BIT_GATE = 7;
  localparam int BIT_CONV = 6;
  localparam int BIT_T2 = 5;
  localparam int BIT_UART = 4;
  localparam int BIT_T1 = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_T0 = 1;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_RSVD = 7;
  // Secondary register fields
  localparam int BIT2_TIC_PR = 6;
  localparam int BIT2_SUP_PR = 5;
  localparam int BIT2_SER_PR = 4;
  localparam int BIT2_TIC_EN = 2;
  localparam int BIT2_SUP_EN = 1;
  localparam int BIT2_SER_EN = 0;

  // ----------------------------------------------------------------
  // Sources in polling order and their vectors
  // ----------------------------------------------------------------
  localparam int NSRC = 11;
  localparam int SRC_SUP = 0;
  localparam int SRC_WDT = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_CONV = 3;
  localparam int SRC_T0 = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_T1 = 6;
  localparam int SRC_SER = 7;
  localparam int SRC_UART = 8;
  localparam int SRC_T2 = 9;
  localparam int SRC_TIC = 10;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_T2 = 16'h002B;
  localparam logic [15:0] VEC_CONV = 16'h0033;
  localparam logic [15:0] VEC_SER = 16'h003B;
  localparam logic [15:0] VEC_SUP = 16'h0043;
  localparam logic [15:0] VEC_TIC = 16'h0053;
  localparam logic [15:0] VEC_WDT = 16'h005B;

  // Arbiter states
  typedef enum logic {ST_IDLE, ST_REQ} arb_state_e;

endpackage

// file: core/irq_poll.sv
// Purpose: Fixed-order picker for one priority level
// Assumes: Request bit 0 is the highest in polling order
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none

module irq_poll
(
  input wire logic [irq_ctrl_pkg::NSRC-1:0] i_req,
  output logic o_found,
  output logic [3:0] o_idx
);

  // ----------------------------------------------------------------
  // Scan from highest to lowest so bit 0 wins
  // ----------------------------------------------------------------
  always_comb
  begin
    o_found = 1'b0;
    o_idx = 4'h0;
    for (int i = irq_ctrl_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (i_req[i])
      begin
        // Earlier position overrides later, see [R10]
        o_found = 1'b1;
        o_idx = 4'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: core/irq_ctrl.sv
// Purpose: Two-level prioritised interrupt controller
// Assumes: Peripheral flags and core strobes are on i_ref_clk
// Notes:   Registers are byte-wide at their special-function addresses
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Special-function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Peripheral request flags
  input wire logic i_supply_mon_irq_flag,
  input wire logic i_watchdog_timeout_flag,
  input wire logic i_ext_irq0_flag,
  input wire logic i_primary_conv_ready,
  input wire logic i_aux_conv_ready,
  input wire logic i_timer0_overflow_flag,
  input wire logic i_ext_irq1_flag,
  input wire logic i_timer1_overflow_flag,
  input wire logic i_twowire_irq_flag,
  input wire logic i_serial_periph_irq_flag,
  input wire logic i_uart_rx_done_flag,
  input wire logic i_uart_tx_done_flag,
  input wire logic i_timer2_overflow_flag,
  input wire logic i_timer2_capture_flag,
  input wire logic i_interval_counter_irq_flag,
  // Watchdog configuration
  input wire logic i_watchdog_irq_mode,
  input wire logic [3:0] i_wdt_timeout_sel,
  // Core handshake
  input wire logic i_irq_ack,
  input wire logic i_reti,
  output logic o_irq_req,
  output logic [15:0] o_irq_vector,
  output logic o_irq_high,
  output logic o_active_high,
  output logic o_active_low,
  output logic o_wdt_reset
);

  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q; // Two-stage release chain
  logic rst_n; // Synchronised active-low reset

  // Deassert through two flops
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] en_main_q; // Main enable
  logic [7:0] prio_main_q; // Main priority
  logic [7:0] en_prio2_q; // Secondary enable and priority
  logic [7:0] prio_main_d; // Priority with reserved bit cleared
  logic wr_en_main; // Write strobe, main enable
  logic wr_prio_main; // Write strobe, main priority
  logic wr_en_prio2; // Write strobe, secondary
  logic rd_hit; // Read address is mapped
  logic [7:0] rd_mux; // Selected read data
  logic [7:0] sfr_rdata_q; // Registered read data
  logic sfr_hit_q; // Registered address hit

  // Address decode
  assign wr_en_main = i_sfr_wr && (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_MAIN);
  assign wr_prio_main = i_sfr_wr && (i_sfr_addr == irq_ctrl_pkg::ADDR_PRIO_MAIN);
  assign wr_en_prio2 = i_sfr_wr && (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_PRIO2);
  assign rd_hit = (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_MAIN) ||
                  (i_sfr_addr == irq_ctrl_pkg::ADDR_PRIO_MAIN) ||
                  (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_PRIO2);

  // Reserved priority bit always stored as zero, see [R03]
  always_comb
  begin
    prio_main_d = i_sfr_wdata;
    prio_main_d[irq_ctrl_pkg::BIT_RSVD] = 1'b0;
  end

  // Read selection, unmapped reads as zero
  assign rd_mux = (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_MAIN) ? en_main_q :
                  (i_sfr_addr == irq_ctrl_pkg::ADDR_PRIO_MAIN) ? prio_main_q :
                  (i_sfr_addr == irq_ctrl_pkg::ADDR_EN_PRIO2) ? en_prio2_q : 8'h00;

  // Enable and priority storage, see [R16]
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_main_q <= irq_ctrl_pkg::RST_EN_MAIN;
      prio_main_q <= irq_ctrl_pkg::RST_PRIO_MAIN;
      en_prio2_q <= irq_ctrl_pkg::RST_EN_PRIO2;
    end
    else
    begin
      // Whole-byte writes only
      if (wr_en_main)
        en_main_q <= i_sfr_wdata;
      if (wr_prio_main)
        prio_main_q <= prio_main_d;
      // Bit 3 kept as written; software keeps it zero, see [R06]
      if (wr_en_prio2)
        en_prio2_q <= i_sfr_wdata;
    end
  end

  // Read port, one cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q <= 1'b0;
    end
    else
    begin
      sfr_rdata_q <= i_sfr_rd ? rd_mux : 8'h00;
      sfr_hit_q <= i_sfr_rd && rd_hit;
    end
  end

  assign o_sfr_rdata = sfr_rdata_q;
  assign o_sfr_hit = sfr_hit_q;

  // ----------------------------------------------------------------
  // Source requests, enables and levels
  // ----------------------------------------------------------------
  logic [irq_ctrl_pkg::NSRC-1:0] req; // Raw requests, polling order
  logic [irq_ctrl_pkg::NSRC-1:0] en; // Per-source enables
  logic [irq_ctrl_pkg::NSRC-1:0] hi; // Level select, 1 is high
  logic [irq_ctrl_pkg::NSRC-1:0] cand; // Requests passing all gates
  logic [irq_ctrl_pkg::NSRC-1:0] hi_cand; // High-level candidates
  logic [irq_ctrl_pkg::NSRC-1:0] lo_cand; // Low-level candidates
  logic gate; // Global gate bit
  logic wdt_req; // Watchdog interrupt request

  // Watchdog request needs mode and nonzero timeout, see [R13] [R15]
  assign wdt_req = i_watchdog_timeout_flag && i_watchdog_irq_mode &&
                   (i_wdt_timeout_sel != 4'h0);

  // Shared-vector flags ORed together, see [R17]
  assign req[irq_ctrl_pkg::SRC_SUP] = i_supply_mon_irq_flag;
  assign req[irq_ctrl_pkg::SRC_WDT] = wdt_req;
  assign req[irq_ctrl_pkg::SRC_EXT0] = i_ext_irq0_flag;
  assign req[irq_ctrl_pkg::SRC_CONV] = i_primary_conv_ready | i_aux_conv_ready;
  assign req[irq_ctrl_pkg::SRC_T0] = i_timer0_overflow_flag;
  assign req[irq_ctrl_pkg::SRC_EXT1] = i_ext_irq1_flag;
  assign req[irq_ctrl_pkg::SRC_T1] = i_timer1_overflow_flag;
  assign req[irq_ctrl_pkg::SRC_SER] = i_twowire_irq_flag | i_serial_periph_irq_flag;
  assign req[irq_ctrl_pkg::SRC_UART] = i_uart_rx_done_flag | i_uart_tx_done_flag;
  assign req[irq_ctrl_pkg::SRC_T2] = i_timer2_overflow_flag | i_timer2_capture_flag;
  assign req[irq_ctrl_pkg::SRC_TIC] = i_interval_counter_irq_flag;

  // Per-source enables, see [R02] [R04]
  assign en[irq_ctrl_pkg::SRC_SUP] = en_prio2_q[irq_ctrl_pkg::BIT2_SUP_EN];
  assign en[irq_ctrl_pkg::SRC_WDT] = 1'b1;
  assign en[irq_ctrl_pkg::SRC_EXT0] = en_main_q[irq_ctrl_pkg::BIT_EXT0];
  assign en[irq_ctrl_pkg::SRC_CONV] = en_main_q[irq_ctrl_pkg::BIT_CONV];
  assign en[irq_ctrl_pkg::SRC_T0] = en_main_q[irq_ctrl_pkg::BIT_T0];
  assign en[irq_ctrl_pkg::SRC_EXT1] = en_main_q[irq_ctrl_pkg::BIT_EXT1];
  assign en[irq_ctrl_pkg::SRC_T1] = en_main_q[irq_ctrl_pkg::BIT_T1];
  assign en[irq_ctrl_pkg::SRC_SER] = en_prio2_q[irq_ctrl_pkg::BIT2_SER_EN];
  assign en[irq_ctrl_pkg::SRC_UART] = en_main_q[irq_ctrl_pkg::BIT_UART];
  assign en[irq_ctrl_pkg::SRC_T2] = en_main_q[irq_ctrl_pkg::BIT_T2];
  assign en[irq_ctrl_pkg::SRC_TIC] = en_prio2_q[irq_ctrl_pkg::BIT2_TIC_EN];

  // Level select; watchdog fixed high, see [R03] [R05] [R14]
  assign hi[irq_ctrl_pkg::SRC_SUP] = en_prio2_q[irq_ctrl_pkg::BIT2_SUP_PR];
  assign hi[irq_ctrl_pkg::SRC_WDT] = 1'b1;
  assign hi[irq_ctrl_pkg::SRC_EXT0] = prio_main_q[irq_ctrl_pkg::BIT_EXT0];
  assign hi[irq_ctrl_pkg::SRC_CONV] = prio_main_q[irq_ctrl_pkg::BIT_CONV];
  assign hi[irq_ctrl_pkg::SRC_T0] = prio_main_q[irq_ctrl_pkg::BIT_T0];
  assign hi[irq_ctrl_pkg::SRC_EXT1] = prio_main_q[irq_ctrl_pkg::BIT_EXT1];
  assign hi[irq_ctrl_pkg::SRC_T1] = prio_main_q[irq_ctrl_pkg::BIT_T1];
  assign hi[irq_ctrl_pkg::SRC_SER] = en_prio2_q[irq_ctrl_pkg::BIT2_SER_PR];
  assign hi[irq_ctrl_pkg::SRC_UART] = prio_main_q[irq_ctrl_pkg::BIT_UART];
  assign hi[irq_ctrl_pkg::SRC_T2] = prio_main_q[irq_ctrl_pkg::BIT_T2];
  assign hi[irq_ctrl_pkg::SRC_TIC] = en_prio2_q[irq_ctrl_pkg::BIT2_TIC_PR];

  // Global gate masks all but the watchdog, see [R01] [R14]
  assign gate = en_main_q[irq_ctrl_pkg::BIT_GATE];

  generate
    for (genvar g = 0; g < irq_ctrl_pkg::NSRC; g++)
    begin : g_cand
      if (g == irq_ctrl_pkg::SRC_WDT)
      begin : g_wdt
        assign cand[g] = req[g];
      end
      else
      begin : g_mask
        assign cand[g] = req[g] & en[g] & gate;
      end
    end
  endgenerate

  assign hi_cand = cand & hi;
  assign lo_cand = cand & ~hi;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic found_hi; // Some high candidate
  logic found_lo; // Some low candidate
  logic [3:0] idx_hi; // First high candidate
  logic [3:0] idx_lo; // First low candidate
  logic take_hi; // High request may be raised
  logic take_lo; // Low request may be raised
  logic [3:0] sel_idx; // Winning source
  logic act_hi_q; // High-level routine active
  logic act_lo_q; // Low-level routine active
  logic act_hi_d;
  logic act_lo_d;
  logic set_hi; // Core accepted a high request
  logic set_lo; // Core accepted a low request
  logic clr_hi; // Return ends high routine
  logic clr_lo; // Return ends low routine
  irq_ctrl_pkg::arb_state_e state_q; // Arbiter state
  logic req_q; // Request to core
  logic [15:0] vec_q; // Vector to core
  logic high_q; // Level of the pending request
  logic wdt_reset_q; // Watchdog reset pulse

  // Vector address per source, see [R12]
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'(irq_ctrl_pkg::SRC_SUP): vec_of = irq_ctrl_pkg::VEC_SUP;
      4'(irq_ctrl_pkg::SRC_WDT): vec_of = irq_ctrl_pkg::VEC_WDT;
      4'(irq_ctrl_pkg::SRC_EXT0): vec_of = irq_ctrl_pkg::VEC_EXT0;
      4'(irq_ctrl_pkg::SRC_CONV): vec_of = irq_ctrl_pkg::VEC_CONV;
      4'(irq_ctrl_pkg::SRC_T0): vec_of = irq_ctrl_pkg::VEC_T0;
      4'(irq_ctrl_pkg::SRC_EXT1): vec_of = irq_ctrl_pkg::VEC_EXT1;
      4'(irq_ctrl_pkg::SRC_T1): vec_of = irq_ctrl_pkg::VEC_T1;
      4'(irq_ctrl_pkg::SRC_SER): vec_of = irq_ctrl_pkg::VEC_SER;
      4'(irq_ctrl_pkg::SRC_UART): vec_of = irq_ctrl_pkg::VEC_UART;
      4'(irq_ctrl_pkg::SRC_T2): vec_of = irq_ctrl_pkg::VEC_T2;
      default: vec_of = irq_ctrl_pkg::VEC_TIC;
    endcase
  endfunction

  // Fixed polling order within each level
  irq_poll u_poll_hi
  (
    .i_req(hi_cand),
    .o_found(found_hi),
    .o_idx(idx_hi)
  );

  irq_poll u_poll_lo
  (
    .i_req(lo_cand),
    .o_found(found_lo),
    .o_idx(idx_lo)
  );

  // High preempts low, never nests in high, see [R07] [R09]
  assign take_hi = found_hi && !act_hi_q;
  // Low only when no routine runs, see [R09]
  assign take_lo = found_lo && !act_hi_q && !act_lo_q;
  // High wins a tie of levels, see [R08]
  assign sel_idx = take_hi ? idx_hi : idx_lo;

  // Active-level tracking, set wins over clear, see [R18]
  assign set_hi = (state_q == irq_ctrl_pkg::ST_REQ) && i_irq_ack && high_q;
  assign set_lo = (state_q == irq_ctrl_pkg::ST_REQ) && i_irq_ack && !high_q;
  assign clr_hi = i_reti && act_hi_q;
  assign clr_lo = i_reti && !act_hi_q && act_lo_q;
  assign act_hi_d = (act_hi_q && !clr_hi) || set_hi;
  assign act_lo_d = (act_lo_q && !clr_lo) || set_lo;

  // Level flags
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end
    else
    begin
      act_hi_q <= act_hi_d;
      act_lo_q <= act_lo_d;
    end
  end

  // Request handshake; vector held until accepted, see [R11]
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= irq_ctrl_pkg::ST_IDLE;
      req_q <= 1'b0;
      vec_q <= 16'h0000;
      high_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        irq_ctrl_pkg::ST_IDLE:
        begin
          // Raise the winner
          if (take_hi || take_lo)
          begin
            state_q <= irq_ctrl_pkg::ST_REQ;
            req_q <= 1'b1;
            vec_q <= vec_of(sel_idx);
            high_q <= take_hi;
          end
        end
        irq_ctrl_pkg::ST_REQ:
        begin
          // Core pushes PC and jumps
          if (i_irq_ack)
          begin
            state_q <= irq_ctrl_pkg::ST_IDLE;
            req_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= irq_ctrl_pkg::ST_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  // Timeout resets only outside interrupt mode, see [R13]
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdt_reset_q <= 1'b0;
    else
      wdt_reset_q <= i_watchdog_timeout_flag && !i_watchdog_irq_mode;
  end

  assign o_irq_req = req_q;
  assign o_irq_vector = vec_q;
  assign o_irq_high = high_q;
  assign o_active_high = act_hi_q;
  assign o_active_low = act_lo_q;
  assign o_wdt_reset = wdt_reset_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic idle; // Arbiter free to raise
  assign idle = (state_q == irq_ctrl_pkg::ST_IDLE);

  property p_gate_off;
    idle && !gate && !wdt_req |=> !o_irq_req;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate off but request"); // see [R01]

  property p_ext0_en;
    $rose(o_irq_req) && o_irq_vector == irq_ctrl_pkg::VEC_EXT0 |-> $past(en_main_q[0]) && $past(gate);
  endproperty
  a_ext0_en: assert property (p_ext0_en) else $error("ext0 raised while disabled"); // see [R02]

  property p_conv_level;
    $rose(o_irq_req) && o_irq_vector == irq_ctrl_pkg::VEC_CONV |-> o_irq_high == $past(prio_main_q[6]);
  endproperty
  a_conv_level: assert property (p_conv_level) else $error("converter level wrong"); // see [R03]

  property p_tic_en;
    $rose(o_irq_req) && o_irq_vector == irq_ctrl_pkg::VEC_TIC |-> $past(en_prio2_q[2]) &&
      o_irq_high == $past(en_prio2_q[6]);
  endproperty
  a_tic_en: assert property (p_tic_en) else $error("interval request bad"); // see [R04] [R05]

  property p_preempt;
    idle && act_lo_q && !act_hi_q && found_hi |=> o_irq_req && o_irq_high;
  endproperty
  a_preempt: assert property (p_preempt) else $error("high did not preempt"); // see [R07]

  property p_high_first;
    idle && !act_hi_q && found_hi && found_lo |=> o_irq_high;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served first"); // see [R08]

  property p_no_nest;
    idle && act_lo_q && !found_hi |=> !o_irq_req;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("same level nested"); // see [R09]

  property p_poll_sup;
    idle && !act_hi_q && hi_cand[0] |=> o_irq_vector == irq_ctrl_pkg::VEC_SUP;
  endproperty
  a_poll_sup: assert property (p_poll_sup) else $error("poll order broken"); // see [R10]

  property p_hold_vec;
    o_irq_req && !i_irq_ack |=> o_irq_req && $stable(o_irq_vector);
  endproperty
  a_hold_vec: assert property (p_hold_vec) else $error("vector dropped early"); // see [R11]

  property p_wdt_irq;
    idle && !act_hi_q && wdt_req && !hi_cand[0] |=> o_irq_req && o_irq_high &&
      o_irq_vector == irq_ctrl_pkg::VEC_WDT;
  endproperty
  a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog not served"); // see [R14]

  property p_wdt_zero;
    idle && i_wdt_timeout_sel == 4'h0 |=> !(o_irq_req && o_irq_vector == irq_ctrl_pkg::VEC_WDT);
  endproperty
  a_wdt_zero: assert property (p_wdt_zero) else $error("watchdog with zero timeout"); // see [R15]

  property p_wdt_rst;
    i_watchdog_timeout_flag && !i_watchdog_irq_mode |=> o_wdt_reset;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing"); // see [R13]

  property p_reti;
    i_reti && act_lo_q && !act_hi_q && !set_lo |=> !o_active_low;
  endproperty
  a_reti: assert property (p_reti) else $error("return left level active"); // see [R18]

  c_preempt: cover property (act_lo_q && set_hi);
  c_wdt: cover property (o_irq_req && o_irq_vector == irq_ctrl_pkg::VEC_WDT);
  c_reti: cover property (i_reti && act_hi_q && act_lo_q);
  c_tie: cover property (idle && found_hi && found_lo);

endmodule
`default_nettype wire

// file: sim/cpu_core_model.sv
// Purpose: Behavioural core that takes interrupts from the controller
// Assumes: Request and vector are registered on the rising edge
// Notes:   Acts on the falling edge; ack delay set by the bench
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
(
  input wire logic i_clk,
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  input wire logic [3:0] i_ack_delay,
  output logic o_irq_ack,
  output logic o_reti,
  output logic [15:0] o_pc
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] stack_q[$]; // Saved program counters
  logic [3:0] wait_q; // Cycles a request has waited

  initial
  begin
    o_irq_ack = 1'b0;
    o_reti = 1'b0;
    o_pc = 16'h0100;
    wait_q = 4'h0;
  end

  // Accept after the delay: push PC, load vector
  always @(negedge i_clk)
  begin
    o_irq_ack <= 1'b0;
    if (i_irq_req !== 1'b1 || o_irq_ack)
      wait_q <= 4'h0;
    else if (wait_q >= i_ack_delay)
    begin
      o_irq_ack <= 1'b1;
      stack_q.push_back(o_pc);
      o_pc <= i_irq_vector;
      wait_q <= 4'h0;
    end
    else
      wait_q <= wait_q + 4'h1;
  end

  // Return from interrupt: one-cycle strobe, pop PC
  task automatic ret();
    @(negedge i_clk);
    o_reti = 1'b1;
    @(negedge i_clk);
    o_reti = 1'b0;
    o_pc = stack_q.pop_back();
  endtask
endmodule

`default_nettype wire

// file: sim/two_level_interrupt_controller_tb_top.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model answers requests on its own
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller_tb_top;
  logic clk, nrst, wr, rd, mode, req, high, act_h, act_l, wrst, ack, reti, hit;
  logic [7:0] addr, wd, rdata;
  logic [14:0] fl; // Peripheral flags, one bit per port
  logic [3:0] sel, dly;
  logic [15:0] vec, pc;
  int err_count, check_count;
  // Sources in polling order: flag masks and vectors
  localparam logic [14:0] MSK [11] = '{15'h0001, 15'h0002, 15'h0004, 15'h0018, 15'h0020,
    15'h0040, 15'h0080, 15'h0300, 15'h0C00, 15'h3000, 15'h4000};
  localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  irq_ctrl dut (.i_ref_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_supply_mon_irq_flag(fl[0]),
    .i_watchdog_timeout_flag(fl[1]), .i_ext_irq0_flag(fl[2]), .i_primary_conv_ready(fl[3]),
    .i_aux_conv_ready(fl[4]), .i_timer0_overflow_flag(fl[5]), .i_ext_irq1_flag(fl[6]),
    .i_timer1_overflow_flag(fl[7]), .i_twowire_irq_flag(fl[8]), .i_serial_periph_irq_flag(fl[9]),
    .i_uart_rx_done_flag(fl[10]), .i_uart_tx_done_flag(fl[11]), .i_timer2_overflow_flag(fl[12]),
    .i_timer2_capture_flag(fl[13]), .i_interval_counter_irq_flag(fl[14]), .i_watchdog_irq_mode(mode),
    .i_wdt_timeout_sel(sel), .i_irq_ack(ack), .i_reti(reti), .o_irq_req(req), .o_irq_vector(vec),
    .o_irq_high(high), .o_active_high(act_h), .o_active_low(act_l), .o_wdt_reset(wrst));

  cpu_core_model core (.i_clk(clk), .i_irq_req(req), .i_irq_vector(vec), .i_ack_delay(dly),
    .o_irq_ack(ack), .o_reti(reti), .o_pc(pc));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("rdata", e, rdata);
    chk("hit", h, hit);
  endtask

  // Wait for the core to accept, then judge vector and level
  task automatic take(input logic [15:0] v, input logic h);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    chk("vector", v, vec);
    chk("level", h, high);
    @(negedge clk);
    chk("pc", v, pc);
  endtask

  // No request may appear for n cycles
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clk);
      chk("req", 0, req);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic vec_test();
    logic [14:0] m;
    wr_b(8'hA8, 8'hFF);
    mode = 1'b1;
    sel = 4'h1;
    for (int k = 0; k < 11; k++)
    begin
      m = MSK[k] & (MSK[k] - 15'h1);
      fl = (m != 0) ? m : MSK[k];
      take(VEC[k], k inside {0, 1, 7, 10});
      fl = 0;
      core.ret();
    end
  endtask

  task automatic poll_test();
    wr_b(8'hA9, 8'h07);
    dly = 4'h3;
    fl = 15'h7FFD;
    for (int k = 0; k < 11; k++)
    begin
      if (k != 1)
      begin
        take(VEC[k], 1'b0);
        fl = fl & ~MSK[k];
        core.ret();
      end
    end
    dly = 4'h0;
  endtask

  task automatic nest_test();
    wr_b(8'hB8, 8'h02);
    fl = 15'h0024;
    take(16'h000B, 1'b1);
    chk("act_h", 1, act_h);
    fl = 15'h0004;
    quiet(5);
    core.ret();
    take(16'h0003, 1'b0);
    fl = 15'h0040;
    quiet(5);
    fl = 15'h0060;
    take(16'h000B, 1'b1);
    chk("act_h", 1, act_h);
    chk("act_l", 1, act_l);
    fl = 15'h0040;
    core.ret();
    chk("act_h", 0, act_h);
    quiet(3);
    core.ret();
    take(16'h0013, 1'b0);
    fl = 0;
    core.ret();
  endtask

  task automatic wdt_test();
    wr_b(8'hA8, 8'h00);
    sel = 4'h0;
    fl = 15'h0002;
    quiet(5);
    sel = 4'h5;
    take(16'h005B, 1'b1);
    chk("wdt_rst", 0, wrst);
    fl = 0;
    core.ret();
    mode = 1'b0;
    fl = 15'h0002;
    repeat (2) @(negedge clk);
    chk("wdt_rst", 1, wrst);
    quiet(3);
    fl = 0;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {nrst, wr, rd, mode, addr, wd, fl, sel, dly} = '0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rdc(8'hA8, 8'h00, 1'b1);
    rdc(8'hA9, 8'hA0, 1'b1);
    rdc(8'hB8, 8'h00, 1'b1);
    rdc(8'hC0, 8'h00, 1'b0);
    wr_b(8'hB8, 8'hFF);
    rdc(8'hB8, 8'h7F, 1'b1);
    wr_b(8'hB8, 8'h00);
    wr_b(8'hA9, 8'h77);
    rdc(8'hA9, 8'h77, 1'b1);
    wr_b(8'hA8, 8'h01);
    fl = 15'h0004;
    quiet(6);
    wr_b(8'hA8, 8'h81);
    take(16'h0003, 1'b0);
    fl = 0;
    core.ret();
    chk("act_l", 0, act_l);
    vec_test();
    poll_test();
    nest_test();
    wdt_test();
    wrap_up();
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
